// file: dpdc_core.v
// power state, clock-enable truth table and command legality of the memory
// assumes command pins are synchronous to the command clock pin, sampled here
`include "dpdc_defines.vh"
`default_nettype none
// Function
// - read done after last data and crc out; write after store and crc returned
// - registered enable high enters power-down, precharge or active variant by banks
// - power-down disables buffers except clocks, error-detect pins, clock enable
// - error-detect pins drive programmed hold pattern in power-down while write clock runs
// - exit on enable low with nop or deselect; exit delay and minimum duration
// - power-down pins: hold pattern if write clock runs, else high; inputs terminated
// - self refresh: error-detect high, inputs terminated, enable driven high
// - act on previous and current enable with command per transition table
// - decode chip select, ras, cas, we into commands
module dpdc_core #(
  parameter NBANK   = `DPDC_NBANK,
  parameter BA_W    = 4,
  parameter XPN_CYC = `DPDC_PD_EXIT_CYC,
  parameter PD_CYC  = `DPDC_MIN_PD_CYC,
  parameter XSR_CYC = `DPDC_SR_EXIT_CYC,
  parameter BST_CYC = `DPDC_BURST_CYC + `DPDC_CRC_CYC
) (
  input  wire            i_clk,        // core clock
  input  wire            i_rst_n,      // async reset
  input  wire            i_cmd_clk,    // command clock pin
  input  wire            i_cke_n,      // clock enable, active low
  input  wire            i_cs_n,       // chip select
  input  wire            i_ras_n,      // row strobe
  input  wire            i_cas_n,      // column strobe
  input  wire            i_we_n,       // write enable
  input  wire [BA_W-1:0] i_bank,       // bank address
  input  wire            i_wdclk_run,  // write data clock running
  input  wire [3:0]      i_hold_pat,   // error-detect hold pattern
  input  wire [3:0]      i_err_det_data, // normal error-detect data
  output reg  [3:0]      o_err_det,    // error-detect pins
  output reg             o_buf_en,     // data/cmd input buffers enabled
  output reg             o_odt,        // inputs terminated
  output reg  [1:0]      o_pwr_state,  // global power state
  output reg             o_precharge_pd, // precharge power-down
  output reg             o_cmd_ok,     // last command accepted
  output reg             o_cmd_err,    // illegal command pulse
  output reg             o_exec_ready  // executable command allowed
);
  wire ck_s;
  wire cke_s;
  wire cs_s;
  wire ras_s;
  wire cas_s;
  wire we_s;
  wire [BA_W-1:0] ba_s;
  wire [5+BA_W:0] async_in;
  wire [5+BA_W:0] sync_out;
  assign async_in = {i_bank, i_we_n, i_ras_n, i_cas_n, i_cs_n, i_cke_n, i_cmd_clk};
  genvar g;
  generate
    for (g = 0; g < 5 + BA_W + 1; g = g + 1) begin : g_sync
      dpdc_sync u_sync (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_d(async_in[g]), .o_q(sync_out[g]));
    end
  endgenerate
  assign {ba_s, we_s, ras_s, cas_s, cs_s, cke_s, ck_s} = sync_out;

  function [2:0] dec_cmd;
    input cs;
    input ras;
    input cas;
    input we;
    begin
      if (cs) dec_cmd = `DPDC_CMD_DESEL;
      else case ({ras, cas, we})
        3'h7:    dec_cmd = `DPDC_CMD_NOP;
        3'h3:    dec_cmd = `DPDC_CMD_ACT;
        3'h1:    dec_cmd = `DPDC_CMD_REF;
        3'h0:    dec_cmd = `DPDC_CMD_MRS;
        3'h5:    dec_cmd = `DPDC_CMD_RD;
        3'h4:    dec_cmd = `DPDC_CMD_WR;
        3'h2:    dec_cmd = `DPDC_CMD_PRE;
        default: dec_cmd = `DPDC_CMD_NOP;
      endcase
    end
  endfunction

  reg        ck_d_ff;
  reg        cke_prev_ff;
  reg [1:0]  pwr_ff;
  reg [1:0]  bank_ff [0:NBANK-1];
  reg [7:0]  burst_ff [0:NBANK-1];
  reg [7:0]  pd_cnt_ff;
  reg [7:0]  exit_cnt_ff;
  wire edge_ck = ck_s & ~ck_d_ff;
  wire [2:0] cmd = dec_cmd(cs_s, ras_s, cas_s, we_s);
  wire nop_like = (cmd == `DPDC_CMD_DESEL) || (cmd == `DPDC_CMD_NOP);
  wire [1:0] cur_bk = bank_ff[ba_s];
  wire cur_busy = burst_ff[ba_s] != 8'h00;

  reg all_idle;
  reg any_burst;
  reg any_read;
  integer k;
  always @* begin
    all_idle  = 1'b1;
    any_burst = 1'b0;
    any_read  = 1'b0;
    for (k = 0; k < NBANK; k = k + 1) begin
      if (bank_ff[k] != `DPDC_BK_IDLE) all_idle = 1'b0;
      if (burst_ff[k] != 8'h00) any_burst = 1'b1;
      if (bank_ff[k] == `DPDC_BK_READ && burst_ff[k] != 8'h00) any_read = 1'b1;
    end
  end

  // legality of a registered command in normal state
  reg legal;
  always @* begin
    legal = 1'b0;
    case (cmd)
      `DPDC_CMD_DESEL, `DPDC_CMD_NOP: legal = 1'b1;
      `DPDC_CMD_ACT: legal = (cur_bk == `DPDC_BK_IDLE);
      `DPDC_CMD_REF, `DPDC_CMD_MRS: legal = all_idle && !any_burst;
      `DPDC_CMD_RD: legal = (cur_bk != `DPDC_BK_IDLE);
      `DPDC_CMD_WR: legal = (cur_bk != `DPDC_BK_IDLE) && !any_read;
      `DPDC_CMD_PRE: legal = (cur_bk != `DPDC_BK_IDLE) && !cur_busy;
      default: legal = 1'b0;
    endcase
    if (exit_cnt_ff != 8'h00 && !nop_like) legal = 1'b0;
  end

  integer b;
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ck_d_ff        <= 1'b0;
      cke_prev_ff    <= 1'b1;
      pwr_ff         <= `DPDC_PW_NORMAL;
      pd_cnt_ff      <= 8'h00;
      exit_cnt_ff    <= 8'h00;
      o_precharge_pd <= 1'b0;
      o_cmd_ok       <= 1'b0;
      o_cmd_err      <= 1'b0;
      for (b = 0; b < NBANK; b = b + 1) begin
        bank_ff[b]  <= `DPDC_BK_IDLE;
        burst_ff[b] <= 8'h00;
      end
    end else begin
      ck_d_ff   <= ck_s;
      o_cmd_err <= 1'b0;
      if (edge_ck) begin
        cke_prev_ff <= cke_s;
        for (b = 0; b < NBANK; b = b + 1) begin
          if (burst_ff[b] != 8'h00) burst_ff[b] <= burst_ff[b] - 8'h01;
        end
        if (exit_cnt_ff != 8'h00) exit_cnt_ff <= exit_cnt_ff - 8'h01;
        if (pd_cnt_ff != 8'h00) pd_cnt_ff <= pd_cnt_ff - 8'h01;
        case ({cke_prev_ff, cke_s})
          2'b11: begin
            o_cmd_ok <= 1'b1;
          end
          2'b10: begin
            if (pwr_ff != `DPDC_PW_NORMAL && nop_like && pd_cnt_ff == 8'h00) begin
              exit_cnt_ff <= (pwr_ff == `DPDC_PW_SR) ? XSR_CYC[7:0] : XPN_CYC[7:0];
              pwr_ff      <= `DPDC_PW_NORMAL;
              o_cmd_ok    <= 1'b1;
            end else if (pwr_ff != `DPDC_PW_NORMAL) begin
              o_cmd_ok  <= 1'b0;
              o_cmd_err <= 1'b1;
            end
          end
          2'b01: begin
            if (cmd == `DPDC_CMD_REF && all_idle && !any_burst) begin
              pwr_ff    <= `DPDC_PW_SR;
              pd_cnt_ff <= PD_CYC[7:0];
              o_cmd_ok  <= 1'b1;
            end else if (nop_like) begin
              pwr_ff         <= `DPDC_PW_PD;
              o_precharge_pd <= all_idle;
              pd_cnt_ff      <= PD_CYC[7:0];
              o_cmd_ok       <= 1'b1;
            end else begin
              o_cmd_ok  <= 1'b0;
              o_cmd_err <= 1'b1;
            end
          end
          default: begin
            o_cmd_ok  <= legal;
            o_cmd_err <= !legal;
            if (legal) begin
              case (cmd)
                `DPDC_CMD_ACT: bank_ff[ba_s] <= `DPDC_BK_ACTIVE;
                `DPDC_CMD_RD: begin
                  bank_ff[ba_s]  <= `DPDC_BK_READ;
                  burst_ff[ba_s] <= BST_CYC[7:0];
                end
                `DPDC_CMD_WR: begin
                  bank_ff[ba_s]  <= `DPDC_BK_WRITE;
                  burst_ff[ba_s] <= BST_CYC[7:0];
                end
                `DPDC_CMD_PRE: bank_ff[ba_s] <= `DPDC_BK_IDLE;
                default: bank_ff[ba_s] <= bank_ff[ba_s];
              endcase
            end
          end
        endcase
      end
    end
  end

  // pin states follow the power state
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_err_det    <= 4'hF;
      o_buf_en     <= 1'b1;
      o_odt        <= 1'b0;
      o_pwr_state  <= `DPDC_PW_NORMAL;
      o_exec_ready <= 1'b1;
    end else begin
      o_pwr_state  <= pwr_ff;
      o_exec_ready <= (pwr_ff == `DPDC_PW_NORMAL) && (exit_cnt_ff == 8'h00);
      case (pwr_ff)
        `DPDC_PW_PD: begin
          o_err_det <= i_wdclk_run ? i_hold_pat : 4'hF;
          o_buf_en <= 1'b0;
          o_odt    <= 1'b1;
        end
        `DPDC_PW_SR: begin
          o_err_det <= 4'hF;
          o_buf_en <= 1'b0;
          o_odt    <= 1'b1;
        end
        default: begin
          o_err_det <= i_err_det_data;
          o_buf_en <= 1'b1;
          o_odt    <= 1'b0;
        end
      endcase
    end
  end
endmodule // dpdc_core
`default_nettype wire

// file: dpdc_defines.vh
// constants for the power-down and command legality block
// assumes a 20 MHz core clock; DPDC_CLK_NS is in ns, other times in command-clock edges
`ifndef DPDC_DEFINES_VH
`define DPDC_DEFINES_VH
`define DPDC_CLK_NS        50
`define DPDC_NBANK         16
`define DPDC_PD_EXIT_CYC   8
`define DPDC_MIN_PD_CYC    4
`define DPDC_SR_EXIT_CYC   16
`define DPDC_BURST_CYC     4
`define DPDC_CRC_CYC       2
`define DPDC_CMD_DESEL     3'h0
`define DPDC_CMD_NOP       3'h1
`define DPDC_CMD_ACT       3'h2
`define DPDC_CMD_REF       3'h3
`define DPDC_CMD_MRS       3'h4
`define DPDC_CMD_RD        3'h5
`define DPDC_CMD_WR        3'h6
`define DPDC_CMD_PRE       3'h7
`define DPDC_PW_NORMAL     2'h0
`define DPDC_PW_PD         2'h1
`define DPDC_PW_SR         2'h2
`define DPDC_BK_IDLE       2'h0
`define DPDC_BK_ACTIVE     2'h1
`define DPDC_BK_READ       2'h2
`define DPDC_BK_WRITE      2'h3
`endif

// file: dpdc_sync.v
// three-flop synchroniser with agreement filter
// assumes input is asynchronous to i_clk
`default_nettype none
module dpdc_sync (
  input  wire i_clk,   // core clock
  input  wire i_rst_n, // async reset
  input  wire i_d,     // async input
  output reg  o_q      // filtered level
);
  reg s1_ff;
  reg s2_ff;
  reg s3_ff;
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
      o_q   <= 1'b0;
    end else begin
      s1_ff <= i_d;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (s2_ff == s3_ff) begin
        o_q <= s3_ff;
      end
    end
  end
endmodule // dpdc_sync
`default_nettype wire

// file: dpdc_properties.sv
// assertions on the ports of the power-down block
// assumes the bind at the foot reaches every dpdc_core
`include "dpdc_defines.vh"
`default_nettype none
module dpdc_properties (
  input wire logic       i_clk,        // core clock
  input wire logic       i_rst_n,      // reset
  input wire logic       i_wdclk_run,  // write clock runs
  input wire logic [3:0] i_hold_pat,   // hold pattern
  input wire logic [3:0] o_err_det,    // error-detect pins
  input wire logic       o_buf_en,     // buffers on
  input wire logic       o_odt,        // terminated
  input wire logic [1:0] o_pwr_state,  // power state
  input wire logic       o_cmd_err,    // error pulse
  input wire logic       o_exec_ready  // exec allowed
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  wire logic pd = o_pwr_state == `DPDC_PW_PD;
  wire logic sr = o_pwr_state == `DPDC_PW_SR;
  AST_PD_BUF: assert property (pd |-> !o_buf_en && o_odt)
    else $error("buffers on in power-down");
  AST_PD_HOLD: assert property (pd && $past(pd) && i_wdclk_run |-> o_err_det == i_hold_pat)
    else $error("error-detect pins lost hold pattern");
  AST_PD_HIGH: assert property (pd && $past(pd) && !i_wdclk_run |-> o_err_det == 4'hF)
    else $error("error-detect pins not high without write clock");
  AST_SR_PINS: assert property (sr |-> o_err_det == 4'hF && o_odt && !o_buf_en)
    else $error("self refresh pin states wrong");
  AST_EXIT_WAIT: assert property ($past(pd) && o_pwr_state == 2'h0 |-> !o_exec_ready)
    else $error("ready at power-down exit");
  AST_READY_LATE: assert property ($rose(o_exec_ready) |-> $past(o_pwr_state, 40) == 2'h0)
    else $error("ready too soon after exit");
  AST_ERR_PULSE: assert property (o_cmd_err |=> !o_cmd_err)
    else $error("error flag longer than a pulse");
  AST_ONE_STEP: assert property ($changed(o_pwr_state) |=> $stable(o_pwr_state) [*6])
    else $error("power state moved twice per edge");
  COV_PD: cover property (pd);
  COV_SR: cover property (sr);
  COV_ERR: cover property (o_cmd_err);
endmodule // dpdc_properties
bind dpdc_core dpdc_properties dpdc_properties_i (.i_clk(i_clk), .i_rst_n(i_rst_n),
  .i_wdclk_run(i_wdclk_run), .i_hold_pat(i_hold_pat), .o_err_det(o_err_det),
  .o_buf_en(o_buf_en),
  .o_odt(o_odt), .o_pwr_state(o_pwr_state), .o_cmd_err(o_cmd_err),
  .o_exec_ready(o_exec_ready));
`default_nettype wire

// file: dpdc_ctrl_model.sv
// controller model: free command clock and command pins
// assumes requests change only between its falling edges
`include "dpdc_defines.vh"
`default_nettype none
module dpdc_ctrl_model (
  input  wire logic       i_cke_n,   // wanted clock enable
  input  wire logic [2:0] i_cmd,     // wanted command
  input  wire logic [3:0] i_bank,    // wanted bank
  output var  logic       o_cmd_clk, // command clock
  output var  logic       o_cke_n,   // clock enable pin
  output var  logic [3:0] o_pins,    // cs ras cas we
  output var  logic [3:0] o_bank     // bank pins
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    o_cmd_clk = 1'b0;
    o_cke_n = 1'b0;
    o_pins = 4'h7;
    o_bank = 4'h0;
    #13;
    forever #200 o_cmd_clk = ~o_cmd_clk;
  end
  // pins move half a period away from the registering edge
  always @(negedge o_cmd_clk) begin
    o_cke_n <= i_cke_n;
    o_bank <= i_bank;
    case (i_cmd)
      `DPDC_CMD_DESEL: o_pins <= {1'b1, ~o_pins[2:0]};
      `DPDC_CMD_NOP: o_pins <= 4'h7;
      `DPDC_CMD_ACT: o_pins <= 4'h3;
      `DPDC_CMD_REF: o_pins <= 4'h1;
      `DPDC_CMD_MRS: o_pins <= 4'h0;
      `DPDC_CMD_RD: o_pins <= 4'h5;
      `DPDC_CMD_WR: o_pins <= 4'h4;
      default: o_pins <= 4'h2;
    endcase
  end
endmodule // dpdc_ctrl_model
`default_nettype wire

// file: dram_power_down_command_control_tb_top.sv
// testbench for the power-down and command legality block
// assumes the controller model drives every command-side pin
`include "dpdc_defines.vh"
`default_nettype none
module dram_power_down_command_control_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic cke_req = 1'b0;
  logic [2:0] cmd_req = `DPDC_CMD_NOP;
  logic [3:0] bank_req = 4'h0;
  logic wdclk_run = 1'b1;
  logic got_err = 1'b0;
  wire logic cmd_clk, cke_n, buf_en, odt, pc_pd, cmd_ok, cmd_err, rdy;
  wire logic [3:0] pins, bank, err_det;
  wire logic [1:0] pwr;
  int miscompares = 0;
  int check_count = 0;
  int err_cnt = 0;
  always #25 i_clk = ~i_clk;
  always @(posedge i_clk) if (cmd_err === 1'b1) err_cnt <= err_cnt + 1;
  dpdc_ctrl_model dpdc_ctrl_model_i (.i_cke_n(cke_req), .i_cmd(cmd_req), .i_bank(bank_req),
    .o_cmd_clk(cmd_clk), .o_cke_n(cke_n), .o_pins(pins), .o_bank(bank));
  dpdc_core dpdc_core_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_cmd_clk(cmd_clk),
    .i_cke_n(cke_n), .i_cs_n(pins[3]), .i_ras_n(pins[2]), .i_cas_n(pins[1]),
    .i_we_n(pins[0]), .i_bank(bank), .i_wdclk_run(wdclk_run), .i_hold_pat(4'hA),
    .i_err_det_data(4'h5), .o_err_det(err_det), .o_buf_en(buf_en), .o_odt(odt),
    .o_pwr_state(pwr),
    .o_precharge_pd(pc_pd), .o_cmd_ok(cmd_ok), .o_cmd_err(cmd_err), .o_exec_ready(rdy));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // two command-clock edges per call: the command, then a filler nop
  task automatic issue(input logic cke, input logic [2:0] c, input logic [3:0] b);
    int e0;
    @(posedge i_clk);
    cke_req <= cke;
    cmd_req <= c;
    bank_req <= b;
    e0 = err_cnt;
    @(negedge cmd_clk);
    @(posedge cmd_clk);
    @(posedge i_clk);
    cmd_req <= `DPDC_CMD_NOP;
    repeat (8) @(posedge i_clk);
    got_err = (err_cnt != e0);
  endtask
  task automatic s_table;
    logic [7:0] t [0:15] = '{8'hD2, 8'h22, 8'hB0, 8'h52, 8'hF2, 8'hE2, 8'h10, 8'h10,
                             8'h62, 8'hF2, 8'h10, 8'h10, 8'h10, 8'h72, 8'h40, 8'h00};
    for (int i = 0; i < 16; i++) begin
      issue(1'b0, t[i][6:4], t[i][3:0]);
      chk(got_err, t[i][7]);
      chk(cmd_ok, !t[i][7]);
    end
  endtask
  task automatic s_exit(input int n_low, input int n_high);
    issue(1'b0, `DPDC_CMD_NOP, 4'h0);
    chk(pwr, `DPDC_PW_NORMAL);
    chk({buf_en, odt, err_det}, 6'h25);
    repeat (n_low) issue(1'b0, `DPDC_CMD_NOP, 4'h0);
    chk(rdy, 1'b0);
    repeat (n_high) issue(1'b0, `DPDC_CMD_NOP, 4'h0);
    chk(rdy, 1'b1);
  endtask
  task automatic s_pd(input logic wdclk, input logic open);
    @(posedge i_clk);
    wdclk_run <= wdclk;
    if (open) issue(1'b0, `DPDC_CMD_ACT, 4'h3);
    issue(1'b1, `DPDC_CMD_NOP, 4'h0);
    chk(pwr, `DPDC_PW_PD);
    chk(pc_pd, !open);
    chk({buf_en, odt}, 2'b01);
    chk(err_det, wdclk ? 4'hA : 4'hF);
    repeat (2) issue(1'b1, `DPDC_CMD_NOP, 4'h0);
    s_exit(3, 2);
    if (open) issue(1'b0, `DPDC_CMD_PRE, 4'h3);
    chk(got_err, 1'b0);
  endtask
  task automatic s_sr;
    issue(1'b1, `DPDC_CMD_REF, 4'h0);
    chk(pwr, `DPDC_PW_SR);
    chk({err_det, odt}, 5'h1F);
    chk(buf_en, 1'b0);
    repeat (2) issue(1'b1, `DPDC_CMD_NOP, 4'h0);
    s_exit(7, 2);
  endtask
  task automatic report_and_stop;
    if (miscompares == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge i_clk);
    miscompares++;
    report_and_stop;
  end
  initial begin
    repeat (12) @(posedge i_clk);
    i_rst_n <= 1'b1;
    repeat (6) @(posedge i_clk);
    s_table;
    s_pd(1'b1, 1'b0);
    s_pd(1'b0, 1'b1);
    s_sr;
    report_and_stop;
  end
endmodule // dram_power_down_command_control_tb_top
`default_nettype wire
